// File: core/option_word_config_decoder.sv
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module option_word_config_decoder (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    // Register port
    input wire logic [optcfg_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [optcfg_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [optcfg_pkg::DATA_W-1:0] reg_rdata,
    // Supply comparators, asynchronous
    input wire logic supply_below_reset,
    input wire logic supply_above_release,
    // Core state, same clock
    input wire logic sleep_mode,
    // Supply reset
    output logic supply_drop_reset,
    output logic [1:0] supply_threshold_sel,
    // Decoded word 0
    output logic config_valid,
    output logic package_20pin,
    output logic package_24pin,
    output logic cycle_length_sel,
    output logic watchdog_enable,
    output logic external_rc_mode,
    output logic internal_rc_mode,
    output logic low_crystal_mode,
    output logic high_crystal_mode,
    output logic watch_crystal_mode,
    output logic mid_crystal_mode,
    output logic osc_out_gpio,
    output logic osc_out_clock,
    output logic osc_out_open_drain,
    output logic osc_in_gpio,
    output logic [2:0] code_protect_en,
    // Decoded words 1 and 2
    output logic ext_reset_en,
    output logic filter_width_sel,
    output logic filter_active,
    output logic filter_mode_sel,
    output logic [1:0] rc_freq_sel,
    output logic [8:0] customer_code
);
    import optcfg_pkg::*;

    function automatic logic is_rc_mode(input logic [2:0] osc);
        return !osc[2];
    endfunction

    // Synchronisers
    logic below_meta_r, below_s_r, above_meta_r, above_s_r;
    // Loader
    load_state_t state_r, state_nxt;
    logic load_req_r, load_req_nxt;
    logic [WORD_W-1:0] cfg0_r, cfg1_r, cfg2_r;
    logic [WORD_W-1:0] cfg0_nxt, cfg1_nxt, cfg2_nxt;
    logic [IDX_W-1:0] mem_rd_idx;
    logic [WORD_W-1:0] mem_rd_data;
    logic mem_wr_en;
    logic reload_wr;
    // Supply supervision
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic drop_r, drop_nxt;
    logic superv_en;
    // Decoded outputs
    logic [1:0] thr_r, thr_nxt;
    logic valid_r, valid_nxt;
    logic pkg20_r, pkg20_nxt, pkg24_r, pkg24_nxt;
    logic cyc_r, cyc_nxt, wdt_r, wdt_nxt;
    logic erc_r, erc_nxt, irc_r, irc_nxt;
    logic lxt_r, lxt_nxt, hxt_r, hxt_nxt;
    logic wxt_r, wxt_nxt, mxt_r, mxt_nxt;
    logic ogpio_r, ogpio_nxt, oclk_r, oclk_nxt;
    logic ood_r, ood_nxt, igpio_r, igpio_nxt;
    logic [2:0] prot_r, prot_nxt;
    logic xrst_r, xrst_nxt, fwid_r, fwid_nxt;
    logic fact_r, fact_nxt, fmode_r, fmode_nxt;
    logic [1:0] rcf_r, rcf_nxt;
    logic [8:0] cid_r, cid_nxt;
    logic [2:0] osc;
    // Register read
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic [DATA_W-1:0] status;

    optword_store u_store (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .ce(ce),
        .wr_en(mem_wr_en),
        .wr_idx(reg_addr[IDX_W-1:0]),
        .wr_data(reg_wdata[WORD_W-1:0]),
        .rd_idx(mem_rd_idx),
        .rd_data(mem_rd_data)
    );

    // Comparators are analog, so only the second stage is ever read
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            below_meta_r <= 1'b0;
            below_s_r <= 1'b0;
            above_meta_r <= 1'b0;
            above_s_r <= 1'b0;
        end
        else if (ce)
        begin
            below_meta_r <= supply_below_reset;
            below_s_r <= below_meta_r;
            above_meta_r <= supply_above_release;
            above_s_r <= above_meta_r;
        end
    end

    always_comb
    begin
        mem_wr_en = reg_wr && reg_addr <= ADDR_WORD2;
        reload_wr = reg_wr && reg_addr == ADDR_CTRL
            && reg_wdata[CTRL_RELOAD];
        state_nxt = state_r;
        cfg0_nxt = cfg0_r;
        cfg1_nxt = cfg1_r;
        cfg2_nxt = cfg2_r;
        mem_rd_idx = '0;
        // A new request set in the taking cycle is kept, not lost
        load_req_nxt = (load_req_r && state_r != LD_IDLE) || reload_wr
            || (drop_nxt && !drop_r);
        case (state_r)
            LD_IDLE:
            begin
                if (load_req_r)
                    state_nxt = LD_W0;
            end
            LD_W0:
            begin
                cfg0_nxt = mem_rd_data;
                mem_rd_idx = 2'h1;
                state_nxt = LD_W1;
            end
            LD_W1:
            begin
                cfg1_nxt = mem_rd_data;
                mem_rd_idx = 2'h2;
                state_nxt = LD_W2;
            end
            LD_W2:
            begin
                cfg2_nxt = mem_rd_data;
                state_nxt = LD_DONE;
            end
            LD_DONE:
            begin
                if (load_req_r)
                    state_nxt = LD_IDLE;
            end
            default:
                state_nxt = LD_IDLE;
        endcase
    end

    // Config regs keep old values while reloading, so supervision
    // never drops out during a reload under reset
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r <= LD_IDLE;
            load_req_r <= 1'b1;
            cfg0_r <= WORD0_DFLT;
            cfg1_r <= WORD1_DFLT;
            cfg2_r <= WORD2_DFLT;
        end
        else if (ce)
        begin
            state_r <= state_nxt;
            load_req_r <= load_req_nxt;
            cfg0_r <= cfg0_nxt;
            cfg1_r <= cfg1_nxt;
            cfg2_r <= cfg2_nxt;
        end
    end

    always_comb
    begin
        superv_en = cfg0_r[W0_THR_HI:W0_THR_LO] != THR_POR_ONLY;
        cnt_nxt = '0;
        drop_nxt = drop_r;
        if (!superv_en)
            drop_nxt = 1'b0;
        else if (drop_r)
        begin
            if (above_s_r)
                drop_nxt = 1'b0;
        end
        else if (below_s_r)
        begin
            if (cnt_r == CNT_W'(DROP_CYCLES - 1))
                drop_nxt = 1'b1;
            else
                cnt_nxt = cnt_r + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_r <= '0;
            drop_r <= 1'b0;
        end
        else if (ce)
        begin
            cnt_r <= cnt_nxt;
            drop_r <= drop_nxt;
        end
    end

    always_comb
    begin
        osc = cfg0_r[W0_OSC_HI:W0_OSC_LO];
        valid_nxt = state_r == LD_DONE;
        thr_nxt = cfg0_r[W0_THR_HI:W0_THR_LO];
        pkg20_nxt = cfg0_r[W0_PKG_HI:W0_PKG_LO] == PKG_20PIN;
        pkg24_nxt = cfg0_r[W0_PKG_HI:W0_PKG_LO] == PKG_24PIN;
        cyc_nxt = cfg0_r[W0_CYCLE];
        wdt_nxt = !cfg0_r[W0_WDT_N];
        erc_nxt = osc[2:1] == OSC_EXT_RC;
        irc_nxt = osc[2:1] == OSC_INT_RC;
        lxt_nxt = osc == OSC_LOW_XTAL;
        hxt_nxt = osc == OSC_HIGH_XTAL;
        wxt_nxt = osc == OSC_WATCH_XTAL;
        mxt_nxt = osc == OSC_MID_XTAL;
        ogpio_nxt = is_rc_mode(osc) && !osc[0];
        igpio_nxt = osc[2:1] == OSC_INT_RC;
        oclk_nxt = is_rc_mode(osc) && osc[0] && cfg1_r[W1_CLKOUT];
        ood_nxt = is_rc_mode(osc) && osc[0] && !cfg1_r[W1_CLKOUT];
        prot_nxt = ~cfg0_r[W0_PROT_HI:0];
        xrst_nxt = !cfg1_r[W1_RSTPIN];
        fwid_nxt = cfg1_r[W1_FWIDTH];
        fact_nxt = cfg1_r[W1_FEN] && osc != OSC_WATCH_XTAL && !sleep_mode;
        fmode_nxt = cfg2_r[W2_FMODE];
        rcf_nxt = cfg1_r[W1_RCF_HI:0];
        cid_nxt = cfg2_r[W2_ID_HI:0];
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            valid_r <= 1'b0;
            thr_r <= THR_POR_ONLY;
            {pkg20_r, pkg24_r, cyc_r, wdt_r} <= 4'h0;
            {erc_r, irc_r, lxt_r, hxt_r, wxt_r, mxt_r} <= 6'h00;
            {ogpio_r, oclk_r, ood_r, igpio_r} <= 4'h0;
            prot_r <= 3'h0;
            {xrst_r, fwid_r, fact_r, fmode_r} <= 4'h0;
            rcf_r <= 2'h0;
            cid_r <= 9'h000;
        end
        else if (ce)
        begin
            valid_r <= valid_nxt;
            thr_r <= thr_nxt;
            {pkg20_r, pkg24_r, cyc_r, wdt_r} <=
                {pkg20_nxt, pkg24_nxt, cyc_nxt, wdt_nxt};
            {erc_r, irc_r, lxt_r, hxt_r, wxt_r, mxt_r} <=
                {erc_nxt, irc_nxt, lxt_nxt, hxt_nxt, wxt_nxt, mxt_nxt};
            {ogpio_r, oclk_r, ood_r, igpio_r} <=
                {ogpio_nxt, oclk_nxt, ood_nxt, igpio_nxt};
            prot_r <= prot_nxt;
            {xrst_r, fwid_r, fact_r, fmode_r} <=
                {xrst_nxt, fwid_nxt, fact_nxt, fmode_nxt};
            rcf_r <= rcf_nxt;
            cid_r <= cid_nxt;
        end
    end

    // Read data stand for one cycle only, zero otherwise
    always_comb
    begin
        status = '0;
        status[STAT_VALID] = valid_r;
        status[STAT_DROP] = drop_r;
        status[STAT_BELOW] = below_s_r;
        status[STAT_ABOVE] = above_s_r;
        status[STAT_LOADING] = state_r != LD_DONE;
        rdata_nxt = '0;
        if (reg_rd)
        begin
            case (reg_addr)
                ADDR_WORD0: rdata_nxt = DATA_W'(cfg0_r);
                ADDR_WORD1: rdata_nxt = DATA_W'(cfg1_r);
                ADDR_WORD2: rdata_nxt = DATA_W'(cfg2_r);
                ADDR_STATUS: rdata_nxt = status;
                ADDR_CTRL: rdata_nxt = DATA_W'(load_req_r);
                default: rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            rdata_r <= '0;
        else if (ce)
            rdata_r <= rdata_nxt;
    end

    assign reg_rdata = rdata_r;
    assign supply_drop_reset = drop_r;
    assign supply_threshold_sel = thr_r;
    assign config_valid = valid_r;
    assign package_20pin = pkg20_r;
    assign package_24pin = pkg24_r;
    assign cycle_length_sel = cyc_r;
    assign watchdog_enable = wdt_r;
    assign external_rc_mode = erc_r;
    assign internal_rc_mode = irc_r;
    assign low_crystal_mode = lxt_r;
    assign high_crystal_mode = hxt_r;
    assign watch_crystal_mode = wxt_r;
    assign mid_crystal_mode = mxt_r;
    assign osc_out_gpio = ogpio_r;
    assign osc_out_clock = oclk_r;
    assign osc_out_open_drain = ood_r;
    assign osc_in_gpio = igpio_r;
    assign code_protect_en = prot_r;
    assign ext_reset_en = xrst_r;
    assign filter_width_sel = fwid_r;
    assign filter_active = fact_r;
    assign filter_mode_sel = fmode_r;
    assign rc_freq_sel = rcf_r;
    assign customer_code = cid_r;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    a_drop_assert: assert property (
        ce && superv_en && !drop_r && below_s_r
        && cnt_r == CNT_W'(DROP_CYCLES - 1) |=> drop_r)
        else $error("supply reset not raised after drop time");
    a_drop_release: assert property (
        ce && drop_r && above_s_r |=> !drop_r)
        else $error("supply reset not released above release level");
    a_threshold_map: assert property (
        valid_r |-> thr_r == cfg0_r[W0_THR_HI:W0_THR_LO])
        else $error("threshold select does not match word 0");
    a_package_map: assert property (
        valid_r |-> pkg20_r == (cfg0_r[12:11] == 2'h1)
        && pkg24_r == (cfg0_r[12:11] == 2'h2))
        else $error("package select wrong");
    a_cycle_len: assert property (
        valid_r |-> cyc_r == cfg0_r[8])
        else $error("cycle length select wrong");
    a_watchdog_en: assert property (
        valid_r |-> wdt_r != cfg0_r[7])
        else $error("watchdog enable polarity wrong");
    a_osc_pin_use: assert property (
        valid_r && !cfg0_r[6] |-> ogpio_r == !cfg0_r[4]
        && (oclk_r || ood_r) == cfg0_r[4])
        else $error("oscillator out pin use wrong");
    a_protect_map: assert property (
        valid_r |-> (prot_r ^ cfg0_r[2:0]) == 3'h7)
        else $error("code protection polarity wrong");
    a_filter_off: assert property (
        ce && (sleep_mode || cfg0_r[6:4] == 3'h6) |=> !fact_r)
        else $error("noise filter active in sleep or watch crystal");
    a_load_order: assert property (
        ce && state_r == LD_W0 ##1 ce |-> state_r == LD_W1 ##1
        state_r == LD_W2)
        else $error("option words not loaded in order");
    a_customer_id: assert property (
        valid_r |-> cid_r == cfg2_r[8:0])
        else $error("customer code not passed through");
endmodule

// File: core/optcfg_pkg.sv
package optcfg_pkg;
    // Register port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [3:0] ADDR_WORD0 = 4'h0;
    localparam logic [3:0] ADDR_WORD1 = 4'h1;
    localparam logic [3:0] ADDR_WORD2 = 4'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h3;
    localparam logic [3:0] ADDR_CTRL = 4'h4;
    localparam int CTRL_RELOAD = 0;
    localparam int STAT_VALID = 0;
    localparam int STAT_DROP = 1;
    localparam int STAT_BELOW = 2;
    localparam int STAT_ABOVE = 3;
    localparam int STAT_LOADING = 4;

    // Option word store
    localparam int WORD_W = 13;
    localparam int NUM_WORDS = 3;
    localparam int IDX_W = 2;
    localparam logic [12:0] WORD0_DFLT = 13'h0FF7;
    localparam logic [12:0] WORD1_DFLT = 13'h17FF;
    localparam logic [12:0] WORD2_DFLT = 13'h0E00;

    // Word 0 fields
    localparam int W0_PKG_HI = 12;
    localparam int W0_PKG_LO = 11;
    localparam int W0_THR_HI = 10;
    localparam int W0_THR_LO = 9;
    localparam int W0_CYCLE = 8;
    localparam int W0_WDT_N = 7;
    localparam int W0_OSC_HI = 6;
    localparam int W0_OSC_LO = 4;
    localparam int W0_PROT_HI = 2;
    // Word 1 fields
    localparam int W1_RSTPIN = 10;
    localparam int W1_CLKOUT = 9;
    localparam int W1_FWIDTH = 8;
    localparam int W1_FEN = 7;
    localparam int W1_RCF_HI = 1;
    // Word 2 fields
    localparam int W2_FMODE = 11;
    localparam int W2_ID_HI = 8;

    // Encodings
    localparam logic [1:0] THR_POR_ONLY = 2'h3;
    localparam logic [1:0] THR_2V5 = 2'h2;
    localparam logic [1:0] THR_3V0 = 2'h1;
    localparam logic [1:0] THR_4V0 = 2'h0;
    localparam logic [1:0] PKG_20PIN = 2'h1;
    localparam logic [1:0] PKG_24PIN = 2'h2;
    localparam logic [1:0] OSC_EXT_RC = 2'h0;
    localparam logic [1:0] OSC_INT_RC = 2'h1;
    localparam logic [2:0] OSC_LOW_XTAL = 3'h4;
    localparam logic [2:0] OSC_HIGH_XTAL = 3'h5;
    localparam logic [2:0] OSC_WATCH_XTAL = 3'h6;
    localparam logic [2:0] OSC_MID_XTAL = 3'h7;

    // Supply drop timing
    localparam int SYS_CLK_MHZ = 200;
    localparam int DROP_TIME_NS = 10000;
    localparam int DROP_CYCLES = (DROP_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 12;

    typedef enum logic [2:0]
    {
        LD_IDLE = 3'h0,
        LD_W0 = 3'h1,
        LD_W1 = 3'h3,
        LD_W2 = 3'h2,
        LD_DONE = 3'h6
    } load_state_t;
endpackage

// File: core/optword_store.sv
`timescale 1ns/10ps
module optword_store (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    // Programming port
    input wire logic wr_en,
    input wire logic [optcfg_pkg::IDX_W-1:0] wr_idx,
    input wire logic [optcfg_pkg::WORD_W-1:0] wr_data,
    // Read port, data one cycle later
    input wire logic [optcfg_pkg::IDX_W-1:0] rd_idx,
    output logic [optcfg_pkg::WORD_W-1:0] rd_data
);
    import optcfg_pkg::*;

    logic [WORD_W-1:0] word_r [NUM_WORDS];
    logic [WORD_W-1:0] word_nxt [NUM_WORDS];
    logic [WORD_W-1:0] rd_data_r;
    logic [WORD_W-1:0] rd_data_nxt;

    always_comb
    begin
        for (int i = 0; i < NUM_WORDS; i++)
        begin
            word_nxt[i] = word_r[i];
            if (wr_en && wr_idx == IDX_W'(i))
                word_nxt[i] = wr_data;
        end
        rd_data_nxt = '0;
        if (32'(rd_idx) < NUM_WORDS)
            rd_data_nxt = word_r[rd_idx];
    end

    // Power-on reset models the unprogrammed, all-default store
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            word_r[0] <= WORD0_DFLT;
            word_r[1] <= WORD1_DFLT;
            word_r[2] <= WORD2_DFLT;
            rd_data_r <= '0;
        end
        else if (ce)
        begin
            word_r <= word_nxt;
            rd_data_r <= rd_data_nxt;
        end
    end

    assign rd_data = rd_data_r;
endmodule

// File: test/option_word_config_decoder_tb.sv
`timescale 1ns/10ps
module option_word_config_decoder_tb;
    import optcfg_pkg::*;
    logic sys_clk;
    logic rstn;
    logic ce;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic supply_below_reset;
    logic supply_above_release;
    logic sleep_mode;
    logic supply_drop_reset;
    logic [1:0] supply_threshold_sel;
    logic config_valid, package_20pin, package_24pin;
    logic cycle_length_sel, watchdog_enable;
    logic external_rc_mode, internal_rc_mode, low_crystal_mode;
    logic high_crystal_mode, watch_crystal_mode, mid_crystal_mode;
    logic osc_out_gpio, osc_out_clock, osc_out_open_drain, osc_in_gpio;
    logic [2:0] code_protect_en;
    logic ext_reset_en, filter_width_sel, filter_active, filter_mode_sel;
    logic [1:0] rc_freq_sel;
    logic [8:0] customer_code;
    int failures;
    int num_checks;
    logic [12:0] w0, w1, w2;

    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    option_word_config_decoder u_option_word_config_decoder
    (
        .sys_clk, .rstn, .ce, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .supply_below_reset, .supply_above_release,
        .sleep_mode, .supply_drop_reset, .supply_threshold_sel,
        .config_valid, .package_20pin, .package_24pin, .cycle_length_sel,
        .watchdog_enable, .external_rc_mode, .internal_rc_mode,
        .low_crystal_mode, .high_crystal_mode, .watch_crystal_mode,
        .mid_crystal_mode, .osc_out_gpio, .osc_out_clock,
        .osc_out_open_drain, .osc_in_gpio, .code_protect_en, .ext_reset_en,
        .filter_width_sel, .filter_active, .filter_mode_sel, .rc_freq_sel,
        .customer_code
    );

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    task automatic wait_cv(input logic lvl);
        int k = 0;
        while (config_valid !== lvl && k < 40)
        begin
            step(1);
            k++;
        end
        chk(16'(config_valid), 16'(lvl));
    endtask

    task automatic reload;
        wr(ADDR_CTRL, 16'h0001);
        wait_cv(1'b0);
        wait_cv(1'b1);
    endtask

    task automatic prog;
        wr(ADDR_WORD0, {3'h0, w0});
        wr(ADDR_WORD1, {3'h0, w1});
        wr(ADDR_WORD2, {3'h0, w2});
        reload();
    endtask

    // Every decoded output against the words last loaded
    task automatic check_all(input logic slp);
        logic [2:0] o;
        o = w0[6:4];
        chk(16'({package_20pin, package_24pin, supply_threshold_sel}),
            16'({w0[12:11] == 2'h1, w0[12:11] == 2'h2, w0[10:9]}));
        chk(16'({cycle_length_sel, watchdog_enable, code_protect_en}),
            16'({w0[8], !w0[7], ~w0[2:0]}));
        chk(16'({external_rc_mode, internal_rc_mode, low_crystal_mode,
            high_crystal_mode, watch_crystal_mode, mid_crystal_mode}),
            16'({o[2:1] == 2'h0, o[2:1] == 2'h1, o == 3'h4, o == 3'h5,
            o == 3'h6, o == 3'h7}));
        chk(16'({osc_out_gpio, osc_out_clock,
            osc_out_open_drain, osc_in_gpio}),
            16'({!o[2] && !o[0], !o[2] && o[0] && w1[9],
            !o[2] && o[0] && !w1[9], o[2:1] == 2'h1}));
        chk(16'({ext_reset_en, filter_width_sel,
            filter_mode_sel, rc_freq_sel}),
            16'({!w1[10], w1[8], w2[11], w1[1:0]}));
        chk(16'(filter_active), 16'(w1[7] && o != 3'h6 && !slp));
        chk(16'(customer_code), 16'(w2[8:0]));
    endtask

    initial
    begin
        rstn = 1'b0;
        ce = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        supply_below_reset = 1'b0;
        supply_above_release = 1'b0;
        sleep_mode = 1'b0;
        failures = 0;
        num_checks = 0;
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        w0 = WORD0_DFLT;
        w1 = WORD1_DFLT;
        w2 = WORD2_DFLT;
        wait_cv(1'b1);
        check_all(1'b0);
        rd_chk(ADDR_WORD0, {3'h0, WORD0_DFLT});
        rd_chk(ADDR_STATUS, 16'h0001);
        rd_chk(4'h7, 16'h0000);
        // Reload request reads back pending; bit 0 clear is ignored
        wr(ADDR_CTRL, 16'h0000);
        rd_chk(ADDR_CTRL, 16'h0000);
        wr(ADDR_CTRL, 16'h0001);
        rd_chk(ADDR_CTRL, 16'h0001);
        wait_cv(1'b1);
        // Enable low freezes the loader, so this request is never taken
        @(posedge sys_clk);
        ce <= 1'b0;
        wr(ADDR_CTRL, 16'h0001);
        ce <= 1'b1;
        step(2);
        chk(16'(config_valid), 16'h0001);
        rd_chk(ADDR_CTRL, 16'h0000);
        // All eight oscillator codes, with sleep on and off
        for (int i = 0; i < 8; i++)
        begin
            w0 = {i[1:0], i[2:1], i[0], ~i[0], i[2:0], 1'b0, i[2:0] ^ 3'h5};
            w1 = {2'b10, i[0], i[1], i[2], ~i[0], 1'b1, 4'hF, i[1:0]};
            w2 = {1'b0, i[1], 2'b11, 9'(i * 37 + 5)};
            prog();
            check_all(1'b0);
            rd_chk(ADDR_WORD1, {3'h0, w1});
            rd_chk(ADDR_WORD2, {3'h0, w2});
            @(posedge sys_clk);
            sleep_mode <= 1'b1;
            step(3);
            check_all(1'b1);
            @(posedge sys_clk);
            sleep_mode <= 1'b0;
            step(3);
        end
        // A store write alone must not move the outputs
        wr(ADDR_WORD0, 16'h1452);
        step(4);
        check_all(1'b0);
        w0 = 13'h1452;
        reload();
        check_all(1'b0);
        // A dip shorter than the filter time restarts the count
        @(posedge sys_clk);
        supply_below_reset <= 1'b1;
        repeat (1500) @(posedge sys_clk);
        supply_below_reset <= 1'b0;
        repeat (5) @(posedge sys_clk);
        supply_below_reset <= 1'b1;
        step(2001);
        chk(16'(supply_drop_reset), 16'h0000);
        step(1);
        chk(16'(supply_drop_reset), 16'h0001);
        // Held while the supply sits between the two levels
        @(posedge sys_clk);
        supply_below_reset <= 1'b0;
        step(10);
        chk(16'(supply_drop_reset), 16'h0001);
        rd_chk(ADDR_STATUS, 16'h0003);
        @(posedge sys_clk);
        supply_above_release <= 1'b1;
        step(2);
        chk(16'(supply_drop_reset), 16'h0001);
        step(1);
        chk(16'(supply_drop_reset), 16'h0000);
        rd_chk(ADDR_STATUS, 16'h0009);
        @(posedge sys_clk);
        supply_above_release <= 1'b0;
        wait_cv(1'b1);
        // Threshold code 11 leaves supervision off
        w0 = WORD0_DFLT;
        prog();
        @(posedge sys_clk);
        supply_below_reset <= 1'b1;
        step(2100);
        chk(16'(supply_drop_reset), 16'h0000);
        rd_chk(ADDR_STATUS, 16'h0005);
        @(posedge sys_clk);
        supply_below_reset <= 1'b0;
        step(4);
        tally_and_finish();
    end

    // The sequence needs about 6000 cycles; this allows a wide margin
    initial
    begin
        #100000;
        failures++;
        tally_and_finish();
    end
endmodule
